// *** rba_card_model.sv ***
/* Card model: register planes and ready pin.
   Assumes registered host pins and a bench-driven device ready vector. */
module rba_card_model #(
  parameter int NDEV = 20
) (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire rba_pkg::rba_pins_t i_pins,
  input  wire logic [19:0]        i_dev,
  output logic      [7:0]         o_data,
  output logic                    o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import rba_pkg::*;
  localparam logic [19:0] PRES = (20'h1 << NDEV) - 20'h1;
  localparam logic [7:0]  PPRS = (8'h1 << (NDEV / 2)) - 8'h1;
  logic [19:0] msk, dev_q, meff, st;
  logic [7:0]  slp, rv, last;
  logic        mode, ready_ack_flag, we_q;
  logic [22:0] wlog[$];
  assign meff = msk | ~PRES;
  assign st = i_dev | ~PRES;
  assign o_ready = (mode & ready_ack_flag) | &(st | meff);
  always_comb begin
    case (i_pins.addr)
      15'h4100: rv = {|meff, 6'h00, o_ready};
      15'h4118: rv = slp;
      15'h4120: rv = meff[7:0];
      15'h4122: rv = meff[15:8];
      15'h4124: rv = {4'h0, meff[19:16]};
      15'h4130: rv = st[7:0];
      15'h4132: rv = st[15:8];
      15'h4134: rv = {4'h0, st[19:16]};
      15'h4140: rv = {6'h00, ready_ack_flag, mode};
      default: rv = 8'h00;
    endcase
  end
  // Released bus shows the inverse of the last byte, so a late sample cannot match
  assign o_data = (!i_pins.ce_n && !i_pins.reg_n && !i_pins.oe_n) ? rv : ~last;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {msk, slp, mode, ready_ack_flag, we_q, last} <= {20'h0, 8'h00, 3'b011, 8'h00};
      dev_q <= 20'hFFFFF;
    end else begin
      if (!i_pins.oe_n) last <= rv;
      dev_q <= i_dev;
      we_q <= i_pins.we_n;
      if (mode && |(i_dev & ~dev_q & ~meff)) ready_ack_flag <= 1'b1;
      if (!we_q && i_pins.we_n && !i_pins.ce_n && !i_pins.reg_n) begin
        wlog.push_back({i_pins.addr, i_pins.data});
        case (i_pins.addr)
          15'h4118: slp <= i_pins.data & PPRS;
          15'h4120: msk[7:0] <= i_pins.data;
          15'h4122: msk[15:8] <= i_pins.data;
          15'h4124: msk[19:16] <= i_pins.data[3:0];
          15'h4140: begin
            mode <= i_pins.data[0];
            if (mode && !i_pins.data[1]) ready_ack_flag <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// *** rba_defines.svh ***
/*
  Constants for the ready/busy aggregator host controller: card register
  offsets, field positions, command layout and access timing.
  Assumes a 100 MHz system clock and an attribute-memory style card port.
*/
// Overview of operation
// - Host enters fast mode: set all masks, write 01H, write 01H again.
// - Mode set and acknowledge clear are separate writes, never one.
// - In fast mode host unmasks a device only after starting its operation.
// - After each completion host writes 01H to the mode register to re-arm.
`ifndef RBA_DEFINES_SVH
`define RBA_DEFINES_SVH

// Card register offsets
`define RBA_CARD_STATUS     15'h4100
`define RBA_SLEEP_CTRL      15'h4118
`define RBA_SLEEP_RSVD      15'h411A
`define RBA_MASK_LOW        15'h4120
`define RBA_MASK_MID        15'h4122
`define RBA_MASK_HIGH       15'h4124
`define RBA_READY_LOW       15'h4130
`define RBA_READY_MID       15'h4132
`define RBA_READY_HIGH      15'h4134
`define RBA_MODE_REG        15'h4140

// Card register values
`define RBA_MASK_ALL        8'hFF
`define RBA_MASK_HIGH_ALL   8'h0F
`define RBA_MODE_HP_VALUE   8'h01
`define RBA_MODE_BIT        0

// Host register byte addresses
`define RBA_HOST_CMD        8'h00
`define RBA_HOST_STATUS     8'h04
`define RBA_HOST_CTRL       8'h08

// Command word fields
`define RBA_CMD_DATA_LSB    0
`define RBA_CMD_ADDR_LSB    8
`define RBA_CMD_OP_LSB      24

// Status and control word fields
`define RBA_ST_BUSY         0
`define RBA_ST_READY        1
`define RBA_ST_HP           2
`define RBA_ST_ACKPEND      3
`define RBA_ST_RDATA_LSB    8
`define RBA_ST_RISES_LSB    16
`define RBA_CTRL_AUTO_ACK   0

// Timing
`define RBA_CLK_MHZ         100
`define RBA_ACCESS_NS       150
// Three pin stages plus the agreement register, and one cycle for a data bit that resolves late
`define RBA_SYNC_LAT        5
`define RBA_ACCESS_CYC      ((`RBA_ACCESS_NS * `RBA_CLK_MHZ + 999) / 1000)
`define RBA_STROBE_CYC      (`RBA_ACCESS_CYC + `RBA_SYNC_LAT)

// Length of the fast-mode entry sequence
`define RBA_HP_STEPS        5

`endif

// *** rba_host_ctrl.sv ***
/*
  Host-side controller for a flash card ready/busy aggregator.
  Software issues card register reads and writes, the fast-mode entry
  sequence and acknowledge writes through a small register port; the
  controller runs attribute-memory cycles on the card pins.
  Assumes the card pins are asynchronous and the card ready pin is high when ready.
*/
`include "rba_defines.svh"

module rba_host_ctrl #(
  parameter int unsigned STROBE_CYC = `RBA_STROBE_CYC
) (
  // Clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_ce,
  // Software register port
  input  wire logic [7:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  // Card pins
  output rba_pkg::rba_pins_t     o_pins,
  input  wire logic [7:0]        i_card_data,
  input  wire logic              i_card_ready
);
  import rba_pkg::*;

  localparam int unsigned CW = $clog2(STROBE_CYC + 1);

  typedef enum logic [1:0] {
    RBA_IDLE,
    RBA_SETUP,
    RBA_STROBE,
    RBA_HOLD
  } rba_state_t;

  rba_state_t  state;
  rba_cmd_t    cur;
  rba_cmd_t    sw_cmd;
  logic [2:0]  step;
  logic [CW-1:0] cnt;
  logic        hp_mode;
  logic        auto_ack;
  logic        ack_pend;
  logic [7:0]  last_rd;
  logic [7:0]  rises;
  logic [7:0]  data_sync;
  logic        ready_sync;
  logic        ready_prev;
  logic        ready_rise;
  logic        sw_start;
  logic        ack_launch;

  // Fixed card writes of the fast-mode entry sequence
  function automatic rba_cmd_t seq_cmd(input logic [2:0] s);
    rba_cmd_t c;
    c.op = RBA_OP_WRITE;
    unique case (s)
      3'h0: begin
        c.addr = `RBA_MASK_LOW;
        c.data = `RBA_MASK_ALL;
      end
      3'h1: begin
        c.addr = `RBA_MASK_MID;
        c.data = `RBA_MASK_ALL;
      end
      3'h2: begin
        c.addr = `RBA_MASK_HIGH;
        c.data = `RBA_MASK_HIGH_ALL;
      end
      default: begin
        c.addr = `RBA_MODE_REG;
        c.data = `RBA_MODE_HP_VALUE;
      end
    endcase
    return c;
  endfunction

  function automatic rba_cmd_t ack_cmd();
    rba_cmd_t c;
    c.op   = RBA_OP_WRITE;
    c.addr = `RBA_MODE_REG;
    c.data = `RBA_MODE_HP_VALUE;
    return c;
  endfunction

  // Ready idles high, so its stages start high and reset shows no rise
  rba_sync #(
    .WIDTH   (9),
    .RST_VAL (9'h100)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_d      ({i_card_ready, i_card_data}),
    .o_q      ({ready_sync, data_sync})
  );

  // A spare bit sits between card address and op, so the fields are picked one by one
  assign sw_cmd     = rba_cmd_t'({i_wdata[`RBA_CMD_OP_LSB+1:`RBA_CMD_OP_LSB],
                                  i_wdata[`RBA_CMD_ADDR_LSB+14:`RBA_CMD_ADDR_LSB],
                                  i_wdata[`RBA_CMD_DATA_LSB+7:`RBA_CMD_DATA_LSB]});
  assign sw_start   = i_wr && (i_addr == `RBA_HOST_CMD) && (state == RBA_IDLE);
  assign ack_launch = !sw_start && (state == RBA_IDLE) && ack_pend;
  assign ready_rise = ready_sync && !ready_prev;

  // Card access sequencer; commands arriving while busy are dropped
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state   <= RBA_IDLE;
      cur     <= '0;
      step    <= '0;
      cnt     <= '0;
      last_rd <= '0;
      hp_mode <= 1'b0;
      o_pins  <= '{reg_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0, data_oe: 1'b0};
    end else if (i_ce) begin
      unique case (state)
        RBA_IDLE: begin
          if (sw_start) begin
            state <= RBA_SETUP;
            if (sw_cmd.op == RBA_OP_HP_ENTER) begin
              cur  <= seq_cmd(3'h0); // masks first, then mode, then ack
              step <= 3'h1;
            end else if (sw_cmd.op == RBA_OP_ACK) begin
              cur <= ack_cmd();
            end else begin
              cur <= sw_cmd; // unmasking after start is software's duty
            end
          end else if (ack_launch) begin
            state <= RBA_SETUP;
            cur   <= ack_cmd(); // re-arm after a completion
          end
        end
        RBA_SETUP: begin
          o_pins.reg_n   <= 1'b0;
          o_pins.ce_n    <= 1'b0;
          o_pins.addr    <= cur.addr;
          o_pins.data    <= cur.data;
          o_pins.data_oe <= (cur.op == RBA_OP_WRITE);
          o_pins.oe_n    <= (cur.op == RBA_OP_WRITE);
          o_pins.we_n    <= (cur.op != RBA_OP_WRITE);
          cnt            <= '0;
          state          <= RBA_STROBE;
        end
        RBA_STROBE: begin
          cnt <= cnt + 1'b1;
          // Strobe covers access time plus synchroniser delay on read data
          if (cnt == CW'(STROBE_CYC - 1)) begin
            o_pins.oe_n <= 1'b1;
            o_pins.we_n <= 1'b1;
            if (cur.op == RBA_OP_READ) begin
              last_rd <= data_sync;
            end
            if (cur.op == RBA_OP_WRITE && cur.addr == `RBA_MODE_REG) begin
              hp_mode <= cur.data[`RBA_MODE_BIT];
            end
            state <= RBA_HOLD;
          end
        end
        RBA_HOLD: begin
          o_pins.ce_n    <= 1'b1;
          o_pins.reg_n   <= 1'b1;
          o_pins.data_oe <= 1'b0;
          // Mode set and ack clear always go out as two separate writes
          if (step != 3'h0 && step < 3'(`RBA_HP_STEPS)) begin
            cur   <= seq_cmd(step);
            step  <= step + 3'h1;
            state <= RBA_SETUP;
          end else begin
            step  <= 3'h0;
            state <= RBA_IDLE;
          end
        end
      endcase
    end
  end

  // Card ready edge tracking; in fast mode each rise is one completion
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ready_prev <= 1'b1;
      rises      <= '0;
    end else if (i_ce) begin
      ready_prev <= ready_sync;
      if (ready_rise) begin
        rises <= rises + 8'h01;
      end
    end
  end

  // Automatic acknowledge request; a new rise wins over the launch clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_pend <= 1'b0;
    end else if (i_ce) begin
      if (ready_rise && hp_mode && auto_ack) begin
        ack_pend <= 1'b1;
      end else if (ack_launch) begin
        ack_pend <= 1'b0;
      end
    end
  end

  // Software control register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      auto_ack <= 1'b0;
    end else if (i_ce && i_wr && i_addr == `RBA_HOST_CTRL) begin
      auto_ack <= i_wdata[`RBA_CTRL_AUTO_ACK];
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= '0;
      if (i_rd) begin
        unique case (i_addr)
          `RBA_HOST_STATUS: begin
            o_rdata[`RBA_ST_BUSY]                       <= (state != RBA_IDLE);
            o_rdata[`RBA_ST_READY]                      <= ready_sync;
            o_rdata[`RBA_ST_HP]                         <= hp_mode;
            o_rdata[`RBA_ST_ACKPEND]                    <= ack_pend;
            o_rdata[`RBA_ST_RDATA_LSB+7:`RBA_ST_RDATA_LSB] <= last_rd;
            o_rdata[`RBA_ST_RISES_LSB+7:`RBA_ST_RISES_LSB] <= rises;
          end
          `RBA_HOST_CTRL: begin
            o_rdata[`RBA_CTRL_AUTO_ACK] <= auto_ack;
          end
          default: begin
            o_rdata <= '0;
          end
        endcase
      end
    end
  end

endmodule

// *** rba_host_ctrl_assertions.sv ***
/* Checker on the host controller ports: card strobe shape, read port timing.
   Assumes the clock enable stays high. */
module rba_host_ctrl_assertions #(
  parameter int unsigned STROBE_CYC = 20
) (
  input wire logic               i_clk,
  input wire logic               i_arst_n,
  input wire logic               i_rd,
  input wire logic [31:0]        o_rdata,
  input wire rba_pkg::rba_pins_t o_pins,
  input wire logic               i_card_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import rba_pkg::*;
  int unsigned cnt;
  logic        act;
  assign act = !o_pins.we_n || !o_pins.oe_n;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) cnt <= 0;
    else cnt <= act ? cnt + 1 : 0;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside answer cycle");
  strobe_excl_a: assert property (!o_pins.we_n |-> o_pins.oe_n)
    else $error("both strobes low");
  strobe_sel_a: assert property (act |-> !o_pins.ce_n && !o_pins.reg_n)
    else $error("strobe without select");
  write_drive_a: assert property (!o_pins.we_n |-> o_pins.data_oe)
    else $error("write without data drive");
  read_float_a: assert property (!o_pins.oe_n |-> !o_pins.data_oe)
    else $error("read while driving data");
  strobe_len_a: assert property ($fell(act) |-> cnt == STROBE_CYC)
    else $error("strobe length wrong");
  addr_hold_a: assert property (!o_pins.ce_n && !$past(o_pins.ce_n) |-> $stable(o_pins.addr))
    else $error("address moved while selected");
  sel_release_a: assert property ($rose(o_pins.ce_n) |-> $past(o_pins.we_n) && $past(o_pins.oe_n) && !o_pins.data_oe)
    else $error("select released early");
  cover property ($rose(o_pins.we_n) && o_pins.addr == 15'h4140);
  cover property ($fell(o_pins.oe_n));
  cover property ($rose(i_card_ready));
endmodule
bind rba_host_ctrl rba_host_ctrl_assertions #(.STROBE_CYC(STROBE_CYC)) u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_pins(o_pins), .i_card_ready(i_card_ready));

// *** rba_host_ctrl_tb_top.sv ***
/* Bench: host controller against the card model.
   Assumes the card model logs every card write in wlog. */
module rba_host_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rba_pkg::*;
  localparam logic [19:0] PRES = 20'h00FFF;
  localparam logic [14:0] RA[7] = '{15'h4100, 15'h4120, 15'h4122, 15'h4124, 15'h4130, 15'h4132, 15'h4134};
  localparam logic [22:0] HPS[5] = '{23'h4120FF, 23'h4122FF, 23'h41240F, 23'h414001, 23'h414001};
  logic        i_clk = 1'b0, i_arst_n = 1'b0, wr = 1'b0, rd = 1'b0, rdy;
  logic [7:0]  addr = 8'h00, cdata, v, r;
  logic [31:0] wdata = 32'h0, rdata, s;
  logic [19:0] dev = 20'hFFFFF, msk = 20'h0;
  rba_pins_t   pins;
  int          errors = 0, n_tests = 0, seed = 32'h14923E5C, n;
  rba_host_ctrl #(.STROBE_CYC(6)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_pins(pins), .i_card_data(cdata), .i_card_ready(rdy));
  rba_card_model #(.NDEV(12)) card (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_pins(pins), .i_dev(dev),
    .o_data(cdata), .o_ready(rdy));
  function automatic logic [7:0] exp_rd(input logic [14:0] a);
    logic [19:0] m, t;
    m = msk | ~PRES;
    t = dev | ~PRES;
    case (a)
      15'h4100: return {|m, 6'h00, &(t | m)};
      15'h4120: return m[7:0];
      15'h4122: return m[15:8];
      15'h4124: return {4'h0, m[19:16]};
      15'h4130: return t[7:0];
      15'h4132: return t[15:8];
      default: return {4'h0, t[19:16]};
    endcase
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic hrd(input logic [7:0] a);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 s = rdata;
  endtask
  task automatic idle();
    n = 0;
    do begin
      hrd(8'h04);
      n++;
    end while (s[0] !== 1'b0 && n < 100);
    if (s[0] !== 1'b0) begin
      errors++;
      $display("FAIL busy expected 0 seen %b", s[0]);
    end
    v = s[15:8];
  endtask
  task automatic cmd(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
    hwr(8'h00, {6'h00, op, 1'b0, a, d});
    idle();
  endtask
  task automatic settle();
    repeat (8) @(posedge i_clk);
    hrd(8'h04);
  endtask
  initial forever #5 i_clk = ~i_clk;
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      cmd(2'd0, RA[i], 8'h00);
      check("reset read", exp_rd(RA[i]), v);
    end
    for (int i = 0; i < 6; i++) begin
      msk = (i == 0) ? 20'h0 : (i == 1) ? 20'hFFFFF : 20'($random(seed));
      dev <= (i == 0) ? 20'hFFFFF : 20'($random(seed));
      cmd(2'd1, 15'h4120, msk[7:0]);
      cmd(2'd1, 15'h4122, msk[15:8]);
      cmd(2'd1, 15'h4124, {4'h0, msk[19:16]});
      for (int k = 0; k < 7; k++) begin
        cmd(2'd0, RA[k], 8'h00);
        check("card register", exp_rd(RA[k]), v);
      end
      settle();
      check("ready pin", &(dev | msk | ~PRES), s[1]);
    end
    @(posedge i_clk);
    addr <= 8'h00;
    wdata <= {6'h00, 2'd1, 1'b0, 15'h4118, 8'hFF};
    wr <= 1'b1;
    @(posedge i_clk);
    wdata <= {6'h00, 2'd1, 1'b0, 15'h4118, 8'h01};
    @(posedge i_clk);
    wr <= 1'b0;
    idle();
    cmd(2'd0, 15'h4118, 8'h00);
    check("sleep pairs", 8'h3F, v);
    hwr(8'h04, 32'hFFFFFFFF);
    hrd(8'h0C);
    check("unmapped read", 32'h0, s);
    dev <= 20'hFFFFE;
    cmd(2'd2, 15'h0000, 8'h00);
    n = card.wlog.size();
    for (int i = 0; i < 5; i++) check("entry order", HPS[i], card.wlog[n - 5 + i]);
    cmd(2'd0, 15'h4140, 8'h00);
    check("mode after entry", 8'h01, v);
    check("fast mode flag", 1'b1, s[2]);
    cmd(2'd1, 15'h4120, 8'hFE);
    settle();
    check("busy in fast mode", 1'b0, s[1]);
    r = s[23:16] + 8'h01;
    dev <= 20'hFFFFF;
    settle();
    check("ready rise", {r, 1'b1}, {s[23:16], s[1]});
    dev <= 20'hFFFFE;
    settle();
    check("held ready", 1'b1, s[1]);
    cmd(2'd3, 15'h0000, 8'h00);
    settle();
    check("busy after ack", 1'b0, s[1]);
    n = card.wlog.size();
    hwr(8'h08, 32'h1);
    dev <= 20'hFFFFF;
    repeat (40) @(posedge i_clk);
    check("auto ack", n + 1, card.wlog.size());
    hrd(8'h08);
    check("auto ack enable", 32'h1, s);
    cmd(2'd0, 15'h4140, 8'h00);
    check("ack cleared", 8'h01, v);
    complete_run();
  end
endmodule

// *** rba_pkg.sv ***
/*
  Types for the ready/busy aggregator host controller.
  Assumes rba_defines.svh is available on the include path.
*/
package rba_pkg;

  typedef enum logic [1:0] {
    RBA_OP_READ,
    RBA_OP_WRITE,
    RBA_OP_HP_ENTER,
    RBA_OP_ACK
  } rba_op_t;

  typedef struct packed {
    rba_op_t     op;
    logic [14:0] addr;
    logic [7:0]  data;
  } rba_cmd_t;

  typedef struct packed {
    logic        reg_n;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [14:0] addr;
    logic [7:0]  data;
    logic        data_oe;
  } rba_pins_t;

endpackage

// *** rba_sync.sv ***
/*
  Three-stage synchroniser for card pins.
  The output follows only when the second and third stages agree.
  Assumes inputs are asynchronous to i_clk.
*/
module rba_sync #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_ce,
  // Data
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  import rba_pkg::*;

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // Reset to the pin's idle level so no false edge follows reset
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else if (i_ce) begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Per bit, a change counts only once two stages agree
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_q <= RST_VAL;
    end else if (i_ce) begin
      o_q <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & o_q);
    end
  end

endmodule
